// [bench/dms_fabric_sink.sv]
// Fabric-side result taker behind the slice output
`timescale 1ns/1ps
module dms_fabric_sink (
    input wire logic aclk,
    input wire logic [47:0] res,
    output logic [47:0] last_ff
);
    // Fabric registers the result on every rising edge, as it would downstream
    always_ff @(posedge aclk) begin
        last_ff <= res;
    end
endmodule

// [bench/dms_top_asserts.sv]
// Bus handshake checker for the multiply-accumulate slice
`timescale 1ns/1ps
module dms_top_asserts
    import dms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // One clock domain, so one clocking and reset for all
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid stuck");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("rvalid stuck");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("no read answer");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read taken");
    a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=>
        !s_axi_awready) else $error("awready held");
    a_aw_back: assert property (s_axi_bvalid && s_axi_bready |=>
        ##[1:2] (s_axi_awready && s_axi_wready)) else $error("no rearm");
    a_ar_back: assert property (s_axi_rvalid && s_axi_rready |=>
        ##[1:2] s_axi_arready) else $error("no read rearm");
    a_bresp_code: assert property (s_axi_bvalid |->
        s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
        else $error("bad bresp");
endmodule

// [bench/testbench.sv]
// Register-level test sequence for the multiply-accumulate slice
`timescale 1ns/1ps
module testbench;
import dms_pkg::*;
logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
logic awready, wready, bvalid, arready, rvalid, det, detb;
logic [7:0] awaddr, araddr;
logic [31:0] wdata, rdata, v;
logic [1:0] bresp, rresp;
logic [47:0] res, fab;
int n_mismatch, comparisons, f;
dms_top i_dms_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .res_out(res),
    .detect_out(det), .detect_b_out(detb));
dms_fabric_sink i_dms_fabric_sink (.aclk(aclk), .res(res), .last_ff(fab));
// Free-running 125 MHz clock
initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
end
// Compare seen against expected, count both outcomes
task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
        n_mismatch++;
        $display("wrong value %s exp %h seen %h", nm, e, s);
    end
endtask
task stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
// Write: address and data offered together, each dropped when taken
task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) break;
    end
    // A lost answer is a hang: count it and end the run
    if (n >= 40) begin
        n_mismatch++;
        stop_test();
    end
    bready <= 1'b0;
    chk("bresp", bresp, er);
endtask
task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) break;
    end
    if (n >= 40) begin
        n_mismatch++;
        stop_test();
    end
    rready <= 1'b0;
    d = rdata;
    chk("rresp", rresp, er);
endtask
// Single step, then let the result settle before looking
task st(input logic [47:0] e);
    wr(CMD_OFS, 32'h00000001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("res_out", res, e);
endtask
// Reference for the ten logic unit functions
function automatic logic [47:0] lf(input int g, input logic [47:0] x, z);
    case (g)
        0: return x & z;
        1: return x | z;
        2: return x ^ z;
        3: return ~(x & z);
        4: return ~(x | z);
        5: return ~(x ^ z);
        6: return x & ~z;
        7: return x | ~z;
        8: return ~x & z;
        default: return ~x | z;
    endcase
endfunction
initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(CTRL_OFS, RESP_OKAY, v);
    chk("ctrl", v, 32'h00000000);
    rd(MASK_LO_OFS, RESP_OKAY, v);
    chk("mask", v, 32'hFFFFFFFF);
    rd(STAT_OFS, RESP_OKAY, v);
    chk("stat", v, 32'h00000003);
    rd(8'h40, RESP_SLVERR, v);
    wr(RES_LO_OFS, 32'h00000001, RESP_SLVERR);
    // Signed product of a negative and a positive operand
    wr(A_OFS, 32'h3FFFFFFD, RESP_OKAY);
    wr(B_OFS, 32'h00000005, RESP_OKAY);
    st(48'hFFFFFFFFFFF1);
    wr(D_OFS, 32'h0000000A, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000002, RESP_OKAY);
    st(48'h000000000023);
    wr(CTRL_OFS, 32'h00000006, RESP_OKAY);
    st(48'h000000000041);
    wr(CTRL_OFS, 32'h00001002, RESP_OKAY);
    st(48'h000000000064);
    st(48'h000000000087);
    wr(A_OFS, 32'h00000001, RESP_OKAY);
    wr(B_OFS, 32'h00000002, RESP_OKAY);
    wr(C_LO_OFS, 32'h00000010, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000001, RESP_OKAY);
    st(48'h000000040012);
    // Lane carry must stop at the 12-bit and 24-bit boundaries
    wr(A_OFS, 32'h00000000, RESP_OKAY);
    wr(B_OFS, 32'h00000001, RESP_OKAY);
    wr(C_LO_OFS, 32'h00000FFF, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000041, RESP_OKAY);
    st(48'h000000000000);
    wr(CTRL_OFS, 32'h00000001, RESP_OKAY);
    st(48'h000000001000);
    wr(C_LO_OFS, 32'h00000000, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000029, RESP_OKAY);
    st(48'h000000FFFFFF);
    wr(B_OFS, 32'h0000F0F0, RESP_OKAY);
    wr(C_LO_OFS, 32'h0000FF00, RESP_OKAY);
    for (f = 0; f < 10; f++) begin
        wr(CTRL_OFS, 32'h00000011 | (f << CTRL_FN_LSB), RESP_OKAY);
        st(lf(f, 48'h00000000F0F0, 48'h00000000FF00));
    end
    wr(CMD_OFS, 32'h00000002, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000018, RESP_OKAY);
    st(48'h000000000001);
    st(48'h000000000002);
    wr(CTRL_OFS, 32'h00000818, RESP_OKAY);
    st(48'h000000000001);
    // Exact-match pattern, then its complement
    wr(MASK_LO_OFS, 32'h00000000, RESP_OKAY);
    wr(MASK_HI_OFS, 32'h00000000, RESP_OKAY);
    wr(PAT_LO_OFS, 32'h00000001, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("det", {det, detb}, 2'b10);
    wr(PAT_LO_OFS, 32'hFFFFFFFE, RESP_OKAY);
    wr(PAT_HI_OFS, 32'h0000FFFF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("detb", {det, detb}, 2'b01);
    wr(B_OFS, 32'h00001001, RESP_OKAY);
    wr(C_LO_OFS, 32'h00000000, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000001, RESP_OKAY);
    st(48'h000000001001);
    rd(STAT_OFS, RESP_OKAY, v);
    chk("xor12", v[9:2], 8'h03);
    wr(CTRL_OFS, 32'h00002001, RESP_OKAY);
    st(48'h000000001001);
    rd(STAT_OFS, RESP_OKAY, v);
    chk("xor24", v[9:2], 8'h00);
    wr(C_LO_OFS, 32'h00000001, RESP_OKAY);
    wr(CTRL_OFS, 32'h00000011, RESP_OKAY);
    st(48'h000000000001);
    chk("and96", {det, detb}, 2'b01);
    // Symmetric rounding at shift 4: 0x18 rounds up to 0x20
    wr(B_OFS, 32'h00000000, RESP_OKAY);
    wr(C_LO_OFS, 32'h00000018, RESP_OKAY);
    wr(CTRL_OFS, 32'h00088001, RESP_OKAY);
    st(48'h000000000018);
    rd(RND_LO_OFS, RESP_OKAY, v);
    chk("round", v, 32'h00000020);
    chk("fabric", fab, 48'h000000000018);
    stop_test();
end
endmodule
bind dms_top dms_top_asserts i_dms_top_asserts (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// [core/dms_lane.sv]
// One carry-splittable adder lane of the arithmetic stage
`timescale 1ns/1ps
module dms_lane #(
    parameter int W = 12
) (
    input wire logic [W-1:0] z,
    input wire logic [W-1:0] x,
    input wire logic cin,
    output logic [W-1:0] sum,
    output logic cout
);
    // Plain ripple sum; the parent decides whether cout reaches the next lane
    assign {cout, sum} = {1'b0, z} + {1'b0, x} + {{W{1'b0}}, cin};
endmodule

// [core/dms_pkg.sv]
// Shared constants for the multiply-accumulate slice and its register map
package dms_pkg;

    // Datapath widths
    localparam int ACC_W = 48;
    localparam int A_W = 27;
    localparam int AX_W = 30;
    localparam int B_W = 18;
    localparam int D_W = 27;
    localparam int PRE_W = 28;
    localparam int LANE_W = 12;
    localparam int LANES = 4;
    localparam int XOR_IN_W = 96;
    localparam int XOR_OUT_W = 8;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] A_OFS = 8'h04;
    localparam logic [7:0] B_OFS = 8'h08;
    localparam logic [7:0] D_OFS = 8'h0C;
    localparam logic [7:0] C_LO_OFS = 8'h10;
    localparam logic [7:0] C_HI_OFS = 8'h14;
    localparam logic [7:0] PAT_LO_OFS = 8'h18;
    localparam logic [7:0] PAT_HI_OFS = 8'h1C;
    localparam logic [7:0] MASK_LO_OFS = 8'h20;
    localparam logic [7:0] MASK_HI_OFS = 8'h24;
    localparam logic [7:0] CMD_OFS = 8'h28;
    localparam logic [7:0] RES_LO_OFS = 8'h2C;
    localparam logic [7:0] RES_HI_OFS = 8'h30;
    localparam logic [7:0] STAT_OFS = 8'h34;
    localparam logic [7:0] RND_LO_OFS = 8'h38;
    localparam logic [7:0] RND_HI_OFS = 8'h3C;

    // Control register field positions
    localparam int CTRL_BYPASS = 0;
    localparam int CTRL_PRE_EN = 1;
    localparam int CTRL_PRE_SUB = 2;
    localparam int CTRL_OP_LSB = 3;
    localparam int CTRL_SIMD_LSB = 5;
    localparam int CTRL_FN_LSB = 7;
    localparam int CTRL_DOWN = 11;
    localparam int CTRL_ZACC = 12;
    localparam int CTRL_XW_LSB = 13;
    localparam int CTRL_RND_LSB = 15;
    localparam int CTRL_SH_LSB = 17;
    localparam int CTRL_RUN = 23;
    localparam int CTRL_USED_W = 24;

    // Command and status bit positions
    localparam int CMD_STEP = 0;
    localparam int CMD_CLR = 1;
    localparam int STAT_DET = 0;
    localparam int STAT_DETB = 1;
    localparam int STAT_XOR_LSB = 2;

    // Reset values
    localparam logic [23:0] CTRL_RST = 24'h000000;
    localparam logic [47:0] PAT_RST = 48'h000000000000;
    localparam logic [47:0] MASK_RST = 48'hFFFFFFFFFFFF;

    // Arithmetic stage functions
    localparam logic [1:0] OP_ADD = 2'h0;
    localparam logic [1:0] OP_SUB = 2'h1;
    localparam logic [1:0] OP_LOGIC = 2'h2;
    localparam logic [1:0] OP_COUNT = 2'h3;

    // Lane arrangements
    localparam logic [1:0] SIMD_ONE48 = 2'h0;
    localparam logic [1:0] SIMD_TWO24 = 2'h1;
    localparam logic [1:0] SIMD_FOUR12 = 2'h2;

    // Logic unit functions of operand x and operand z
    localparam logic [3:0] FN_AND = 4'h0;
    localparam logic [3:0] FN_OR = 4'h1;
    localparam logic [3:0] FN_XOR = 4'h2;
    localparam logic [3:0] FN_NAND = 4'h3;
    localparam logic [3:0] FN_NOR = 4'h4;
    localparam logic [3:0] FN_XNOR = 4'h5;
    localparam logic [3:0] FN_X_ANDN_Z = 4'h6;
    localparam logic [3:0] FN_X_ORN_Z = 4'h7;
    localparam logic [3:0] FN_NX_AND_Z = 4'h8;
    localparam logic [3:0] FN_NX_OR_Z = 4'h9;

    // Wide XOR segment widths
    localparam logic [1:0] XW_12 = 2'h0;
    localparam logic [1:0] XW_24 = 2'h1;
    localparam logic [1:0] XW_48 = 2'h2;
    localparam logic [1:0] XW_96 = 2'h3;

    // Rounding modes
    localparam logic [1:0] RND_NONE = 2'h0;
    localparam logic [1:0] RND_SYM = 2'h1;
    localparam logic [1:0] RND_CONV = 2'h2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [core/dms_top.sv]
// Multiply-accumulate slice with AXI4-Lite register access
`timescale 1ns/1ps
module dms_top
    import dms_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ACC_W-1:0] res_out,
    output logic detect_out,
    output logic detect_b_out
);

    // Bus slave state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic aw_got_ff, w_got_ff; // Address or data already latched
    logic [ADDR_W-1:0] waddr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic do_wr; // Write commits this cycle

    // Software-visible operand and configuration registers
    logic [CTRL_USED_W-1:0] ctrl_ff;
    logic [AX_W-1:0] a_ff;
    logic [B_W-1:0] b_ff;
    logic [D_W-1:0] d_ff;
    logic [ACC_W-1:0] c_ff, pat_ff, mask_ff;
    logic step_ff, clr_ff; // One-cycle command pulses

    // Result and derived state
    logic [ACC_W-1:0] p_ff, nxt_p, rnd_ff, nxt_rnd;
    logic det_ff, detb_ff;
    logic [XOR_OUT_W-1:0] xor_ff, xor_c;

    // Control field views
    logic bypass, pre_en, pre_sub, down, zacc, run, ce;
    logic [1:0] op, simd, xw, rmode;
    logic [3:0] fn;
    logic [5:0] sh;

    assign bypass = ctrl_ff[CTRL_BYPASS];
    assign pre_en = ctrl_ff[CTRL_PRE_EN];
    assign pre_sub = ctrl_ff[CTRL_PRE_SUB];
    assign op = ctrl_ff[CTRL_OP_LSB +: 2];
    assign simd = ctrl_ff[CTRL_SIMD_LSB +: 2];
    assign fn = ctrl_ff[CTRL_FN_LSB +: 4];
    assign down = ctrl_ff[CTRL_DOWN];
    assign zacc = ctrl_ff[CTRL_ZACC];
    assign xw = ctrl_ff[CTRL_XW_LSB +: 2];
    assign rmode = ctrl_ff[CTRL_RND_LSB +: 2];
    assign sh = ctrl_ff[CTRL_SH_LSB +: 6];
    assign run = ctrl_ff[CTRL_RUN];
    // Clock enable: free-running or single step
    assign ce = run | step_ff;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Write address channel: latch once, hold until the response leaves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            waddr_ff <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_got_ff <= 1'b1;
            waddr_ff <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_got_ff <= 1'b0;
        end else if (!aw_got_ff && !bvalid_ff) begin
            awready_ff <= 1'b1;
        end
    end

    // Write data channel, independent of the address order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b0;
            w_got_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (do_wr) begin
            w_got_ff <= 1'b0;
        end else if (!w_got_ff && !bvalid_ff) begin
            wready_ff <= 1'b1;
        end
    end

    assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;

    // Write response; unmapped or read-only offsets answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            if (waddr_ff <= CMD_OFS && waddr_ff[1:0] == 2'h0) begin
                bresp_ff <= RESP_OKAY;
            end else begin
                bresp_ff <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Operand and configuration registers, updated by bus writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RST;
            a_ff <= '0;
            b_ff <= '0;
            d_ff <= '0;
            c_ff <= '0;
            pat_ff <= PAT_RST;
            mask_ff <= MASK_RST;
        end else if (do_wr) begin
            // Registered inputs: fabric values are sampled here
            if (waddr_ff == CTRL_OFS) begin
                ctrl_ff <= CTRL_USED_W'(merge(32'(ctrl_ff), wdata_ff,
                    wstrb_ff));
            end else if (waddr_ff == A_OFS) begin
                a_ff <= AX_W'(merge(32'(a_ff), wdata_ff, wstrb_ff));
            end else if (waddr_ff == B_OFS) begin
                b_ff <= B_W'(merge(32'(b_ff), wdata_ff, wstrb_ff));
            end else if (waddr_ff == D_OFS) begin
                d_ff <= D_W'(merge(32'(d_ff), wdata_ff, wstrb_ff));
            end else if (waddr_ff == C_LO_OFS) begin
                c_ff[31:0] <= merge(c_ff[31:0], wdata_ff, wstrb_ff);
            end else if (waddr_ff == C_HI_OFS) begin
                c_ff[47:32] <= 16'(merge(32'(c_ff[47:32]), wdata_ff,
                    wstrb_ff));
            end else if (waddr_ff == PAT_LO_OFS) begin
                pat_ff[31:0] <= merge(pat_ff[31:0], wdata_ff, wstrb_ff);
            end else if (waddr_ff == PAT_HI_OFS) begin
                pat_ff[47:32] <= 16'(merge(32'(pat_ff[47:32]), wdata_ff,
                    wstrb_ff));
            end else if (waddr_ff == MASK_LO_OFS) begin
                mask_ff[31:0] <= merge(mask_ff[31:0], wdata_ff, wstrb_ff);
            end else if (waddr_ff == MASK_HI_OFS) begin
                mask_ff[47:32] <= 16'(merge(32'(mask_ff[47:32]), wdata_ff,
                    wstrb_ff));
            end
        end
    end

    // Command pulses last exactly one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_ff <= 1'b0;
            clr_ff <= 1'b0;
        end else begin
            step_ff <= do_wr && waddr_ff == CMD_OFS && wstrb_ff[0]
                && wdata_ff[CMD_STEP];
            clr_ff <= do_wr && waddr_ff == CMD_OFS && wstrb_ff[0]
                && wdata_ff[CMD_CLR];
        end
    end

    // Pre-adder and multiplier
    logic signed [PRE_W-1:0] a_s, d_s, pre;
    logic signed [PRE_W+B_W-1:0] prod;
    logic [ACC_W-1:0] x, z, logic_res, lane_res, cnt_res;

    assign a_s = PRE_W'(signed'(a_ff[A_W-1:0]));
    assign d_s = PRE_W'(signed'(d_ff));
    // Symmetric taps share one multiply through d plus or minus a
    assign pre = !pre_en ? a_s : (pre_sub ? d_s - a_s : d_s + a_s);
    // Two's complement product, sign extended to accumulator width
    assign prod = pre * signed'(b_ff);
    // Bypass concatenates the operand registers into a 48-bit word
    assign x = bypass ? {a_ff, b_ff} : ACC_W'(prod);
    // Second operand: running total or the c operand
    assign z = zacc ? p_ff : c_ff;

    // Lane adders; carries break at lane edges chosen by simd
    logic [LANES:0] cy;
    logic [LANES-1:0] lane_cin;
    logic sub;
    assign sub = op == OP_SUB;
    assign cy[0] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            // Subtract adds the inverse plus one per independent lane
            assign lane_cin[gi] = (gi == 0 || simd == SIMD_FOUR12
                || (simd == SIMD_TWO24 && gi == 2)) ? sub : cy[gi];
            dms_lane #(.W(LANE_W)) u_lane (
                .z(z[gi*LANE_W +: LANE_W]),
                .x(sub ? ~x[gi*LANE_W +: LANE_W] : x[gi*LANE_W +: LANE_W]),
                .cin(lane_cin[gi]),
                .sum(lane_res[gi*LANE_W +: LANE_W]),
                .cout(cy[gi+1])
            );
        end
    endgenerate

    // Ten bitwise functions of the two operands
    always_comb begin
        case (fn)
            FN_AND: logic_res = x & z;
            FN_OR: logic_res = x | z;
            FN_XOR: logic_res = x ^ z;
            FN_NAND: logic_res = ~(x & z);
            FN_NOR: logic_res = ~(x | z);
            FN_XNOR: logic_res = ~(x ^ z);
            FN_X_ANDN_Z: logic_res = x & ~z;
            FN_X_ORN_Z: logic_res = x | ~z;
            FN_NX_AND_Z: logic_res = ~x & z;
            FN_NX_OR_Z: logic_res = ~x | z;
            default: logic_res = '0;
        endcase
    end

    // Up/down counter on the stored total
    assign cnt_res = down ? p_ff - 48'h000000000001
        : p_ff + 48'h000000000001;

    // Next result selection
    always_comb begin
        case (op)
            OP_ADD: nxt_p = lane_res;
            OP_SUB: nxt_p = lane_res;
            OP_LOGIC: nxt_p = logic_res;
            default: nxt_p = cnt_res;
        endcase
    end

    // Result register: clear wins over a step in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_ff) begin
            p_ff <= '0;
        end else if (ce) begin
            p_ff <= nxt_p;
        end
    end

    // Pattern detector on the registered result
    logic det_c, detb_c;
    // With the logic unit in front, 96 input bits decide one flag
    assign det_c = ((p_ff ^ pat_ff) & ~mask_ff) == '0;
    assign detb_c = ((p_ff ^ ~pat_ff) & ~mask_ff) == '0;

    // Rounding at bit position sh; with sh of zero RND_SYM lowers a negative result by one and RND_CONV clears bit 0 on det_c
    logic [ACC_W-1:0] half, lowm, rsum;
    assign half = (sh == 6'h00) ? '0 : 48'h000000000001 << (sh - 6'h01);
    assign lowm = (48'h000000000001 << sh) - 48'h000000000001;
    always_comb begin
        rsum = p_ff + half;
        if (rmode == RND_SYM && p_ff[ACC_W-1]) begin
            // Negative ties round away from zero
            rsum = p_ff + half - 48'h000000000001;
        end
        nxt_rnd = rsum & ~lowm;
        if (rmode == RND_CONV && det_c) begin
            // Detector flags an exact tie: force the kept LSB even
            nxt_rnd = nxt_rnd & ~(48'h000000000001 << sh);
        end
        if (rmode == RND_NONE) begin
            nxt_rnd = p_ff;
        end
    end

    // Wide XOR over both operands feeding the arithmetic stage
    dms_xor u_xor (
        .din({z, x}),
        .width(xw),
        .xout(xor_c)
    );

    // Derived state follows the result and operands by one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_ff <= 1'b0;
            detb_ff <= 1'b0;
            rnd_ff <= '0;
            xor_ff <= '0;
        end else begin
            det_ff <= det_c;
            detb_ff <= detb_c;
            rnd_ff <= nxt_rnd;
            xor_ff <= xor_c;
        end
    end

    assign res_out = p_ff;
    assign detect_out = det_ff;
    assign detect_b_out = detb_ff;

    // Read channel: one word per request, answered the next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            if (s_axi_araddr == CTRL_OFS) begin
                rdata_ff <= 32'(ctrl_ff);
            end else if (s_axi_araddr == A_OFS) begin
                rdata_ff <= 32'(a_ff);
            end else if (s_axi_araddr == B_OFS) begin
                rdata_ff <= 32'(b_ff);
            end else if (s_axi_araddr == D_OFS) begin
                rdata_ff <= 32'(d_ff);
            end else if (s_axi_araddr == C_LO_OFS) begin
                rdata_ff <= c_ff[31:0];
            end else if (s_axi_araddr == C_HI_OFS) begin
                rdata_ff <= 32'(c_ff[47:32]);
            end else if (s_axi_araddr == PAT_LO_OFS) begin
                rdata_ff <= pat_ff[31:0];
            end else if (s_axi_araddr == PAT_HI_OFS) begin
                rdata_ff <= 32'(pat_ff[47:32]);
            end else if (s_axi_araddr == MASK_LO_OFS) begin
                rdata_ff <= mask_ff[31:0];
            end else if (s_axi_araddr == MASK_HI_OFS) begin
                rdata_ff <= 32'(mask_ff[47:32]);
            end else if (s_axi_araddr == CMD_OFS) begin
                // Command bits are pulses and always read zero
                rdata_ff <= '0;
            end else if (s_axi_araddr == RES_LO_OFS) begin
                rdata_ff <= p_ff[31:0];
            end else if (s_axi_araddr == RES_HI_OFS) begin
                rdata_ff <= 32'(p_ff[47:32]);
            end else if (s_axi_araddr == STAT_OFS) begin
                rdata_ff <= 32'({xor_ff, detb_ff, det_ff});
            end else if (s_axi_araddr == RND_LO_OFS) begin
                rdata_ff <= rnd_ff[31:0];
            end else if (s_axi_araddr == RND_HI_OFS) begin
                rdata_ff <= 32'(rnd_ff[47:32]);
            end else begin
                rdata_ff <= '0;
                rresp_ff <= RESP_SLVERR;
            end
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

endmodule

// [core/dms_xor.sv]
// Width-programmable wide XOR reduction
`timescale 1ns/1ps
module dms_xor
    import dms_pkg::*;
(
    input wire logic [XOR_IN_W-1:0] din,
    input wire logic [1:0] width,
    output logic [XOR_OUT_W-1:0] xout
);
    logic [XOR_OUT_W-1:0] seg; // Parity of each 12-bit segment

    // Base 12-bit segment parities
    always_comb begin
        for (int i = 0; i < XOR_OUT_W; i++) begin
            seg[i] = ^din[i*LANE_W +: LANE_W];
        end
    end

    // Fold segments according to the selected width; unused bits read zero
    always_comb begin
        xout = '0;
        if (width == XW_12) begin
            xout = seg;
        end else if (width == XW_24) begin
            for (int i = 0; i < 4; i++) begin
                xout[i] = seg[2*i] ^ seg[2*i+1];
            end
        end else if (width == XW_48) begin
            xout[0] = ^seg[3:0];
            xout[1] = ^seg[7:4];
        end else begin
            xout[0] = ^seg;
        end
    end
endmodule
